// ### src/alarm_status_aggregator.sv
// Operation
// - Summary bit: any unmasked flag set
// - Status select routes summary onto pin
// - Bit 5 set on lane FIFO fault
// - Per-lane FIFO fault register identifies lanes
// - Bit 4 set while PLL unlocked
// - 8B/10B: bit 3 when enabled, not transmitting
// - 64B/66B: bit 3 on start, realignment
// - Bit 2 set on SYSREF clock realign
// - Bit 0 set on divider mismatch
// - Write one clears; flags otherwise sticky
// - Reset sets status to 0x3F
// - Flags undefined while link disabled, except clock
// - Summary register reset 0, read-only
// - Per-flag mask, reset 1, blocks summary
// - Lane bit set on fault, W1C
// - Status FIFO bit write clears lanes
`timescale 1ns/1ps
`default_nettype none
module alarm_status_aggregator #(
  parameter int LANES = 8
) (
  input wire logic clk_sys, // 100 MHz system clock
  input wire logic srst, // Sync reset, power-on or soft
  input wire logic [9:0] regAddr, // Register address
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  input wire logic [7:0] regWdata, // Write data
  output logic [7:0] regRdata, // Read data, registered
  input wire logic link_transmitter_enable, // Link enabled
  input wire logic encMode, // 0 = 8B/10B, 1 = 64B/66B
  input wire logic data_transmission_state, // Link in data state (8B/10B)
  input wire logic linkStartup, // 64B/66B startup pulse
  input wire logic linkRealign, // 64B/66B FIFO/serializer realign pulse
  input wire logic [LANES-1:0] laneFault, // Lane FIFO over/underflow
  input wire logic pllLocked, // Serializer PLL lock
  input wire logic sysrefRealign, // SYSREF realigned clocks pulse
  input wire logic dividerMismatch, // A/B dividers differ from C/D
  input wire logic calStatusSel, // Route summary onto pin
  input wire logic calDone, // Normal calibration status
  output logic calibration_status_pin // Calibration status output
);
  asa_evt_if evt();
  logic [7:0] mask_reg;
  logic summary_reg;

  // Strobe qualified by one register address
  function automatic logic regHit(input logic strobe, input logic [9:0] addr, input logic [9:0] target);
    regHit = strobe && addr == target;
  endfunction : regHit

  // Any implemented flag that its mask lets through
  function automatic logic anyUnmasked(input logic [7:0] flags, input logic [7:0] mask);
    anyUnmasked = |(flags & ~mask & asa_pkg::FLAG_IMPL);
  endfunction : anyUnmasked

  wire logic wrFlags = regHit(regWr, regAddr, asa_pkg::ADDR_ALARM_FLAGS);
  wire logic wrLane = regHit(regWr, regAddr, asa_pkg::ADDR_PER_LANE_FIFO_FAULT);
  wire logic wrMask = regHit(regWr, regAddr, asa_pkg::ADDR_ALARM_FLAG_MASK);
  wire logic enc8 = encMode == asa_pkg::ENC_8B10B;
  wire logic linkEvt = enc8 ? (link_transmitter_enable && !data_transmission_state)
                            : (linkStartup || linkRealign);
  // Events outside the clock alarm only count while the link is enabled
  wire logic en = link_transmitter_enable;
  wire logic [7:0] setMask = {2'b00, en && |laneFault, en && !pllLocked, en && linkEvt,
                              en && sysrefRealign, 1'b0, dividerMismatch};
  wire logic summaryNext = anyUnmasked(evt.flags, mask_reg);
  wire logic [7:0] rdMux = regAddr == asa_pkg::ADDR_ALARM_SUMMARY ? {7'h00, summary_reg} :
                           regAddr == asa_pkg::ADDR_ALARM_FLAGS ? evt.flags :
                           regAddr == asa_pkg::ADDR_ALARM_FLAG_MASK ? mask_reg :
                           regAddr == asa_pkg::ADDR_PER_LANE_FIFO_FAULT ? evt.laneFlags : 8'h00;

  assign evt.setMask = setMask;

  asa_flag_core #(.LANES(LANES)) u_core (
    .clk_sys(clk_sys),
    .srst(srst),
    .laneFault(en ? laneFault : '0),
    .wrFlags(wrFlags),
    .wrLane(wrLane),
    .wrData(regWdata),
    .evt(evt)
  );

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      mask_reg <= asa_pkg::RST_MASK;
      summary_reg <= asa_pkg::RST_SUMMARY[0];
      regRdata <= 8'h00;
      calibration_status_pin <= 1'b0;
    end
    else
    begin
      if (wrMask)
        mask_reg <= regWdata & asa_pkg::MASK_WR | 8'h02;
      summary_reg <= summaryNext;
      if (regRd)
        regRdata <= rdMux;
      calibration_status_pin <= calStatusSel ? summaryNext : calDone;
    end
  end

  property p_summary;
    @(posedge clk_sys) disable iff (srst)
    anyUnmasked(evt.flags, mask_reg) |=> summary_reg;
  endproperty
  a_summary: assert property (p_summary) else $error("Summary not raised");

  property p_pin;
    @(posedge clk_sys) disable iff (srst)
    calStatusSel && summaryNext |=> calibration_status_pin;
  endproperty
  a_pin: assert property (p_pin) else $error("Alarm not on pin");

  property p_masked;
    @(posedge clk_sys) disable iff (srst)
    !anyUnmasked(evt.flags, mask_reg) |=> !summary_reg;
  endproperty
  a_masked: assert property (p_masked) else $error("Masked alarm leaked");

  property p_pll;
    @(posedge clk_sys) disable iff (srst)
    en && !pllLocked |=> evt.flags[asa_pkg::BIT_SPLL];
  endproperty
  a_pll: assert property (p_pll) else $error("PLL flag missing");

  sequence s_lane_event;
    en && |laneFault;
  endsequence

  property p_fifo;
    @(posedge clk_sys) disable iff (srst)
    s_lane_event |=> evt.flags[asa_pkg::BIT_FIFO] && |evt.laneFlags;
  endproperty
  a_fifo: assert property (p_fifo) else $error("FIFO flag or lane bit missing");

  sequence s_link_idle8;
    en && enc8 && !data_transmission_state;
  endsequence

  property p_link8;
    @(posedge clk_sys) disable iff (srst)
    s_link_idle8 |=> evt.flags[asa_pkg::BIT_LINK];
  endproperty
  a_link8: assert property (p_link8) else $error("Link flag missing in 8B/10B");

  sequence s_link_evt66;
    en && !enc8 && (linkStartup || linkRealign);
  endsequence

  property p_link66;
    @(posedge clk_sys) disable iff (srst)
    s_link_evt66 |=> evt.flags[asa_pkg::BIT_LINK];
  endproperty
  a_link66: assert property (p_link66) else $error("Link flag missing in 64B/66B");

  property p_realign;
    @(posedge clk_sys) disable iff (srst)
    en && sysrefRealign |=> evt.flags[asa_pkg::BIT_REALIGN];
  endproperty
  a_realign: assert property (p_realign) else $error("Realign flag missing");

  // The clock alarm stays live while the link is disabled
  property p_clk;
    @(posedge clk_sys) disable iff (srst)
    dividerMismatch |=> evt.flags[asa_pkg::BIT_CLK];
  endproperty
  a_clk: assert property (p_clk) else $error("Clock flag missing");

  sequence s_clear_realign;
    wrFlags && regWdata[asa_pkg::BIT_REALIGN] && !evt.setMask[asa_pkg::BIT_REALIGN];
  endsequence

  property p_clear_hold;
    @(posedge clk_sys) disable iff (srst)
    s_clear_realign ##1 !evt.setMask[asa_pkg::BIT_REALIGN] |=> !evt.flags[asa_pkg::BIT_REALIGN];
  endproperty
  a_clear_hold: assert property (p_clear_hold) else $error("Cleared flag came back");

  property p_zero_write;
    @(posedge clk_sys) disable iff (srst)
    wrFlags && regWdata == 8'h00 |=> (evt.flags & $past(evt.flags)) == $past(evt.flags);
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("Zero write dropped a flag");

  property p_read_summary;
    @(posedge clk_sys) disable iff (srst)
    regRd && regAddr == asa_pkg::ADDR_ALARM_SUMMARY |=> regRdata == {7'h00, $past(summary_reg)};
  endproperty
  a_read_summary: assert property (p_read_summary) else $error("Summary read wrong");

  property p_read_flags;
    @(posedge clk_sys) disable iff (srst)
    regRd && regAddr == asa_pkg::ADDR_ALARM_FLAGS |=> regRdata == $past(evt.flags);
  endproperty
  a_read_flags: assert property (p_read_flags) else $error("Status read wrong");

  property p_read_mask;
    @(posedge clk_sys) disable iff (srst)
    regRd && regAddr == asa_pkg::ADDR_ALARM_FLAG_MASK |=> regRdata == $past(mask_reg);
  endproperty
  a_read_mask: assert property (p_read_mask) else $error("Mask read wrong");

  property p_read_lanes;
    @(posedge clk_sys) disable iff (srst)
    regRd && regAddr == asa_pkg::ADDR_PER_LANE_FIFO_FAULT |=> regRdata == $past(evt.laneFlags);
  endproperty
  a_read_lanes: assert property (p_read_lanes) else $error("Lane read wrong");

  property p_pin_sel;
    @(posedge clk_sys) disable iff (srst)
    calStatusSel |=> calibration_status_pin == summary_reg;
  endproperty
  a_pin_sel: assert property (p_pin_sel) else $error("Pin does not follow summary");

  property p_pin_off;
    @(posedge clk_sys) disable iff (srst)
    !calStatusSel |=> calibration_status_pin == $past(calDone);
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("Pin does not follow calibration");

  property p_mask_rsvd;
    @(posedge clk_sys) disable iff (srst)
    mask_reg[7:6] == 2'b00 && mask_reg[1];
  endproperty
  a_mask_rsvd: assert property (p_mask_rsvd) else $error("Reserved mask bits wrong");
endmodule : alarm_status_aggregator
`default_nettype wire

// ### src/asa_evt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface asa_evt_if;
  logic [7:0] setMask;
  logic [7:0] flags;
  logic [7:0] laneFlags;
  modport core (input setMask, output flags, output laneFlags);
  modport top (output setMask, input flags, input laneFlags);
endinterface : asa_evt_if
`default_nettype wire

// ### src/asa_flag_core.sv
`timescale 1ns/1ps
`default_nettype none
module asa_flag_core #(
  parameter int LANES = 8
) (
  input wire logic clk_sys, // System clock
  input wire logic srst, // Sync reset, also soft reset
  input wire logic [LANES-1:0] laneFault, // Per-lane FIFO over/underflow
  input wire logic wrFlags, // Write strobe, status register
  input wire logic wrLane, // Write strobe, per-lane register
  input wire logic [7:0] wrData, // Write data
  asa_evt_if.core evt // Status set conditions and flag state
);
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [LANES-1:0] lane_reg;
  logic [LANES-1:0] lane_next;
  wire logic [7:0] clrFlags = wrFlags ? wrData : 8'h00;
  wire logic clrAllLanes = wrFlags & wrData[asa_pkg::BIT_FIFO];
  wire logic [LANES-1:0] clrLane = wrLane ? wrData[LANES-1:0] : '0;

  // Set beats clear; writing 0 leaves flags alone; bits 7:6 stay 0, bit 1 holds
  assign flags_next = ((flags_reg & ~clrFlags) | evt.setMask) & asa_pkg::FLAG_IMPL
                      | (flags_reg & 8'h02);
  // Whole-lane clear through the status register's FIFO bit
  assign lane_next = (lane_reg & ~clrLane & {LANES{~clrAllLanes}}) | laneFault;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      flags_reg <= asa_pkg::RST_FLAGS;
      lane_reg <= asa_pkg::RST_LANE[LANES-1:0];
    end
    else
    begin
      flags_reg <= flags_next;
      lane_reg <= lane_next;
    end
  end

  assign evt.flags = flags_reg;
  assign evt.laneFlags = 8'(lane_reg);

  property p_set_wins;
    @(posedge clk_sys) disable iff (srst)
    evt.setMask[asa_pkg::BIT_SPLL] |=> flags_reg[asa_pkg::BIT_SPLL];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("PLL flag not set");

  property p_w1c;
    @(posedge clk_sys) disable iff (srst)
    wrFlags && wrData[asa_pkg::BIT_CLK] && !evt.setMask[asa_pkg::BIT_CLK] |=> !flags_reg[asa_pkg::BIT_CLK];
  endproperty
  a_w1c: assert property (p_w1c) else $error("Clock flag not cleared");

  property p_sticky;
    @(posedge clk_sys) disable iff (srst)
    flags_reg[asa_pkg::BIT_LINK] && !(wrFlags && wrData[asa_pkg::BIT_LINK]) |=> flags_reg[asa_pkg::BIT_LINK];
  endproperty
  a_sticky: assert property (p_sticky) else $error("Link flag dropped");

  property p_lane_clr_all;
    @(posedge clk_sys) disable iff (srst)
    clrAllLanes && laneFault == '0 |=> lane_reg == '0;
  endproperty
  a_lane_clr_all: assert property (p_lane_clr_all) else $error("Lane flags not cleared");

  property p_rsvd;
    @(posedge clk_sys) disable iff (srst)
    flags_reg[7:6] == 2'b00 && flags_reg[1];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("Reserved status bits wrong");

  property p_lane_set;
    @(posedge clk_sys) disable iff (srst)
    laneFault[0] |=> lane_reg[0];
  endproperty
  a_lane_set: assert property (p_lane_set) else $error("Lane 0 flag not set");
endmodule : asa_flag_core
`default_nettype wire

// ### src/asa_pkg.sv
package asa_pkg;
  localparam logic [9:0] ADDR_ALARM_SUMMARY = 10'h2c0;
  localparam logic [9:0] ADDR_ALARM_FLAGS = 10'h2c1;
  localparam logic [9:0] ADDR_ALARM_FLAG_MASK = 10'h2c2;
  localparam logic [9:0] ADDR_PER_LANE_FIFO_FAULT = 10'h2c4;
  localparam int BIT_SUMMARY = 0;
  localparam int BIT_FIFO = 5;
  localparam int BIT_SPLL = 4;
  localparam int BIT_LINK = 3;
  localparam int BIT_REALIGN = 2;
  localparam int BIT_RSVD = 1;
  localparam int BIT_CLK = 0;
  localparam logic [7:0] RST_SUMMARY = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h3f;
  localparam logic [7:0] RST_MASK = 8'h3f;
  localparam logic [7:0] RST_LANE = 8'hff;
  localparam logic [7:0] FLAG_IMPL = 8'h3d;
  localparam logic [7:0] MASK_WR = 8'h3f;
  typedef enum logic {ENC_8B10B, ENC_64B66B} asa_enc_t;
endpackage : asa_pkg

// ### test/alarm_status_aggregator_tb.sv
`timescale 1ns/1ps
`default_nettype none
module alarm_status_aggregator_tb;
  localparam logic [9:0] AS = asa_pkg::ADDR_ALARM_SUMMARY;
  localparam logic [9:0] AF = asa_pkg::ADDR_ALARM_FLAGS;
  localparam logic [9:0] AM = asa_pkg::ADDR_ALARM_FLAG_MASK;
  localparam logic [9:0] AL = asa_pkg::ADDR_PER_LANE_FIFO_FAULT;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [9:0] regAddr = 10'h000;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic link_transmitter_enable = 1'b1;
  logic encMode = 1'b0;
  logic calStatusSel = 1'b1;
  logic calDone = 1'b0;
  logic calibration_status_pin;
  logic [6:0] ev = 7'h00;
  logic [7:0] bitTab [7] = '{8'h01, 8'h10, 8'h08, 8'h08, 8'h04, 8'h20, 8'h08};
  int badCount = 0;
  int nTests = 0;
  int cyc = 0;
  // One event source per slot, all inactive at zero
  wire dividerMismatch = ev[0];
  wire pllLocked = ~ev[1];
  wire data_transmission_state = ~ev[2];
  wire linkStartup = ev[3];
  wire sysrefRealign = ev[4];
  wire [7:0] laneFault = {4'h0, ev[5], 3'h0};
  wire linkRealign = ev[6];
  alarm_status_aggregator #(.LANES(8)) uut (.clk_sys, .srst, .regAddr, .regWr, .regRd, .regWdata, .regRdata,
    .link_transmitter_enable, .encMode, .data_transmission_state, .linkStartup, .linkRealign, .laneFault,
    .pllLocked, .sysrefRealign, .dividerMismatch, .calStatusSel, .calDone, .calibration_status_pin);
  initial forever #5 clk_sys = ~clk_sys;
  task automatic conclude();
    $display("compares %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp)
    begin
      badCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    regAddr = a;
    regWdata = d;
    regWr = 1'b1;
    @(negedge clk_sys);
    regWr = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask : wr
  // Write with one event source raised in the same strobe cycle
  task automatic wrSet(input int k, input logic [9:0] a, input logic [7:0] d);
    ev[k] = 1'b1;
    regAddr = a;
    regWdata = d;
    regWr = 1'b1;
    @(negedge clk_sys);
    ev[k] = 1'b0;
    regWr = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask : wrSet
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    regAddr = a;
    regRd = 1'b1;
    @(negedge clk_sys);
    regRd = 1'b0;
    chk(regRdata, e);
    @(negedge clk_sys);
  endtask : rd
  task automatic pulse(input int k);
    ev[k] = 1'b1;
    @(negedge clk_sys);
    ev[k] = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask : pulse
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      badCount++;
      conclude();
    end
  end
  initial
  begin
    repeat (12) @(negedge clk_sys);
    srst = 1'b0;
    @(negedge clk_sys);
    rd(AS, 8'h00);
    rd(AF, 8'h3f);
    rd(AM, 8'h3f);
    rd(AL, 8'hff);
    wr(AF, 8'hff);
    rd(AF, 8'h02);
    rd(AL, 8'h00);
    wr(AS, 8'hff);
    rd(AS, 8'h00);
    wr(AM, 8'hff);
    rd(AM, 8'h3f);
    wr(AM, 8'h00);
    rd(AM, 8'h02);
    rd(AS, 8'h00);
    $display("test reset done");
    for (int k = 0; k < 7; k++)
    begin
      encMode = (k == 3 || k == 6);
      wr(AF, 8'hff);
      rd(AF, 8'h02);
      pulse(k);
      rd(AF, 8'h02 | bitTab[k]);
      rd(AS, 8'h01);
      chk({7'h00, calibration_status_pin}, 8'h01);
      if (k == 5)
        rd(AL, 8'h08);
      wr(AF, bitTab[k]);
      rd(AF, 8'h02);
      rd(AL, 8'h00);
    end
    $display("test events done");
    encMode = 1'b0;
    wrSet(0, AF, 8'h01);
    rd(AF, 8'h03);
    wr(AF, 8'h00);
    rd(AF, 8'h03);
    wr(AM, 8'h01);
    rd(AS, 8'h00);
    chk({7'h00, calibration_status_pin}, 8'h00);
    wr(AM, 8'h00);
    rd(AS, 8'h01);
    wr(AF, 8'h01);
    rd(AS, 8'h00);
    pulse(5);
    wr(AL, 8'h08);
    rd(AL, 8'h00);
    rd(AF, 8'h22);
    calStatusSel = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk({7'h00, calibration_status_pin}, 8'h00);
    calDone = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk({7'h00, calibration_status_pin}, 8'h01);
    link_transmitter_enable = 1'b0;
    wr(AF, 8'hff);
    pulse(1);
    pulse(0);
    rd(AF, 8'h03);
    link_transmitter_enable = 1'b1;
    $display("test sticky done");
    srst = 1'b1;
    repeat (3) @(negedge clk_sys);
    srst = 1'b0;
    @(negedge clk_sys);
    rd(AS, 8'h00);
    rd(AF, 8'h3f);
    rd(AM, 8'h3f);
    rd(AL, 8'hff);
    $display("test rereset done");
    conclude();
  end
endmodule : alarm_status_aggregator_tb
`default_nettype wire
